// ===== hw/rficb_pkg.sv
// package: register map, field layout and reset values of the rf/if configuration bank
package rficb_pkg;
    // word indices; byte address is four times the index
    localparam logic [3:0] RFICB_IDX_CONFIG = 4'h0;
    localparam logic [3:0] RFICB_IDX_TEST2 = 4'h9;
    localparam logic [3:0] RFICB_IDX_CLKDIV = 4'hA;
    localparam int RFICB_ADDR_W = 6;

    // first configuration word fields
    localparam int RFICB_POS_ENABLE = 31;
    localparam int RFICB_POS_IDLE = 30;
    localparam int RFICB_POS_RSVA_HI = 29;
    localparam int RFICB_POS_RSVA_LO = 26;
    localparam int RFICB_POS_RSVB_HI = 25;
    localparam int RFICB_POS_RSVB_LO = 22;
    localparam int RFICB_POS_POLE = 17;
    localparam int RFICB_POS_AMP_HI = 16;
    localparam int RFICB_POS_AMP_LO = 15;
    localparam int RFICB_POS_MIX_HI = 14;
    localparam int RFICB_POS_MIX_LO = 13;
    localparam int RFICB_POS_CEN_HI = 12;
    localparam int RFICB_POS_CEN_LO = 6;
    localparam int RFICB_POS_BW_HI = 5;
    localparam int RFICB_POS_BW_LO = 3;
    localparam int RFICB_POS_ORDER = 2;
    localparam int RFICB_POS_TYPE = 1;
    localparam int RFICB_POS_GAIN = 0;
    localparam logic [3:0] RFICB_RSVA_PATTERN = 4'hF;
    localparam logic [3:0] RFICB_RSVB_PATTERN = 4'hA;

    // reset image: enable=1 idle=0 rsv=8,8,2,1 pole/amp/mix=0 centre=0x58 bw=0 order=0 type=1 gain=1
    localparam logic [31:0] RFICB_CONFIG_RESET = 32'hA2241603;

    // sample-clock divider word fields
    localparam int RFICB_POS_LCNT_HI = 27;
    localparam int RFICB_POS_LCNT_LO = 16;
    localparam int RFICB_POS_MCNT_HI = 15;
    localparam int RFICB_POS_MCNT_LO = 4;
    localparam int RFICB_POS_PREFRAC = 3;
    localparam int RFICB_POS_CLKOUT = 2;
    // divider reset value is not given; plain default, adjustable
    localparam logic [31:0] RFICB_CLKDIV_RESET = 32'h00000000;
    localparam logic [31:0] RFICB_CLKDIV_MASK = 32'h0FFFFFFC;

    // test word is wholly reserved; held as written, reset plain default
    localparam logic [31:0] RFICB_TEST2_RESET = 32'h00000000;

    localparam logic [1:0] RFICB_CODE_HIGH = 2'h0;
    localparam logic [1:0] RFICB_CODE_LOW = 2'h1;
    localparam logic [1:0] RFICB_CODE_OFF = 2'h2;
endpackage

// ===== hw/rficb_band_decode.sv
// band-select decoder: two-bit mode code to high/low enables
`timescale 1ns/100ps
module rficb_band_decode
    import rficb_pkg::*;
(
    input wire logic [1:0] code,
    input wire logic chipOn,
    output logic highEn,
    output logic lowEn
);
    // reserved code 3 and the off code both leave the stage disabled
    assign highEn = chipOn && (code == RFICB_CODE_HIGH);
    assign lowEn = chipOn && (code == RFICB_CODE_LOW);
endmodule

// ===== hw/rficb_filter_ctrl.sv
// if filter control: bandwidth legality and steering outputs
`timescale 1ns/100ps
module rficb_filter_ctrl
    import rficb_pkg::*;
(
    input wire logic [2:0] bwCode,
    input wire logic typeComplex,
    input wire logic chipOn,
    output logic bwValid,
    output logic filterOn
);
    // codes 3,4,7 only allowed with lowpass; 5,6 reserved
    always_comb begin
        case (bwCode)
            3'h0, 3'h1, 3'h2: bwValid = 1'b1;
            3'h3, 3'h4, 3'h7: bwValid = !typeComplex;
            default: bwValid = 1'b0;
        endcase
    end
    assign filterOn = chipOn;
endmodule

// ===== hw/rficb_bank.sv
// rf/if configuration register bank with avalon-mm slave
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/100ps
// Contract
// - bit31 chip enable, reset one
// - bit30 idle select, reset zero
// - bit17 mixer pole 13/36 MHz
// - bits16:15 amplifier band select
// - bits14:13 mixer band select
// - bits12:6 filter centre, reset 0x58
// - bits5:3 bandwidth, lowpass-only codes
// - bit2 filter order select
// - bit1 filter type, reset one
// - bit0 filter gain, reset one
// - divider word L, M, select bits
module rficb_bank
    import rficb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [RFICB_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic [1:0] response,
    output logic device_enable,
    output logic idleMode,
    output logic mixer_pole_select,
    output logic [1:0] amplifier_band_select,
    output logic [1:0] mixer_band_select,
    output logic [6:0] filter_centre_setting,
    output logic [2:0] filter_bandwidth_select,
    output logic filter_order_select,
    output logic filter_type_select,
    output logic filter_gain_select,
    output logic highAmpEn,
    output logic lowAmpEn,
    output logic highMixEn,
    output logic lowMixEn,
    output logic filterOn,
    output logic bandwidthValid,
    output logic [11:0] sample_div_l_count,
    output logic [11:0] sample_div_m_count,
    output logic pre_fractional_divider_select,
    output logic clock_output_select,
    output logic [31:0] testWord
);
    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    // one wait cycle per access: request seen, answered on the next edge
    logic ack_reg;
    logic [31:0] configWord_reg;
    logic [31:0] clkDiv_reg;
    logic [31:0] test2_reg;
    logic [3:0] wordIdx;
    logic accept;
    logic [31:0] beMask;

    assign wordIdx = address[RFICB_ADDR_W-1:2];
    assign accept = (read || write) && !ack_reg;
    assign waitrequest = (read || write) && !ack_reg;
    assign beMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                     {8{byteenable[1]}}, {8{byteenable[0]}}};

    function automatic logic isMapped(input logic [3:0] idx);
        isMapped = (idx == RFICB_IDX_CONFIG) || (idx == RFICB_IDX_TEST2) ||
                   (idx == RFICB_IDX_CLKDIV);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= accept;
        end
    end

    // ----------------------------------------
    // register storage
    // ----------------------------------------
    // storage keeps running while chip enable is low: only the bus stays alive then
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            configWord_reg <= RFICB_CONFIG_RESET;
        end else if (accept && write && wordIdx == RFICB_IDX_CONFIG) begin
            // reserved fields are stored as written; the host keeps their patterns
            configWord_reg <= merge(configWord_reg, writedata, beMask);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clkDiv_reg <= RFICB_CLKDIV_RESET;
        end else if (accept && write && wordIdx == RFICB_IDX_CLKDIV) begin
            clkDiv_reg <= merge(clkDiv_reg, writedata, beMask & RFICB_CLKDIV_MASK);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            test2_reg <= RFICB_TEST2_RESET;
        end else if (accept && write && wordIdx == RFICB_IDX_TEST2) begin
            test2_reg <= merge(test2_reg, writedata, beMask);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readdata <= 32'h00000000;
            response <= 2'h0;
        end else if (accept && read) begin
            response <= isMapped(wordIdx) ? 2'h0 : 2'h2;
            case (wordIdx)
                RFICB_IDX_CONFIG: readdata <= configWord_reg;
                RFICB_IDX_TEST2: readdata <= test2_reg;
                RFICB_IDX_CLKDIV: readdata <= clkDiv_reg;
                default: readdata <= 32'h00000000;
            endcase
        end else if (accept && write) begin
            response <= isMapped(wordIdx) ? 2'h0 : 2'h2;
        end
    end

    // ----------------------------------------
    // field outputs
    // ----------------------------------------
    assign device_enable = configWord_reg[RFICB_POS_ENABLE];
    assign idleMode = configWord_reg[RFICB_POS_IDLE];
    assign mixer_pole_select = configWord_reg[RFICB_POS_POLE];
    assign amplifier_band_select = configWord_reg[RFICB_POS_AMP_HI:RFICB_POS_AMP_LO];
    assign mixer_band_select = configWord_reg[RFICB_POS_MIX_HI:RFICB_POS_MIX_LO];
    assign filter_centre_setting = configWord_reg[RFICB_POS_CEN_HI:RFICB_POS_CEN_LO];
    assign filter_bandwidth_select = configWord_reg[RFICB_POS_BW_HI:RFICB_POS_BW_LO];
    assign filter_order_select = configWord_reg[RFICB_POS_ORDER];
    assign filter_type_select = configWord_reg[RFICB_POS_TYPE];
    assign filter_gain_select = configWord_reg[RFICB_POS_GAIN];
    assign sample_div_l_count = clkDiv_reg[RFICB_POS_LCNT_HI:RFICB_POS_LCNT_LO];
    assign sample_div_m_count = clkDiv_reg[RFICB_POS_MCNT_HI:RFICB_POS_MCNT_LO];
    assign pre_fractional_divider_select = clkDiv_reg[RFICB_POS_PREFRAC];
    assign clock_output_select = clkDiv_reg[RFICB_POS_CLKOUT];
    assign testWord = test2_reg;

    // ----------------------------------------
    // front-end steering
    // ----------------------------------------
    // idle also shuts the signal path, but registers are untouched
    logic chipOn;
    assign chipOn = device_enable && !idleMode;

    rficb_band_decode u_ampDecode (
        .code(amplifier_band_select),
        .chipOn(chipOn),
        .highEn(highAmpEn),
        .lowEn(lowAmpEn)
    );

    rficb_band_decode u_mixDecode (
        .code(mixer_band_select),
        .chipOn(chipOn),
        .highEn(highMixEn),
        .lowEn(lowMixEn)
    );

    rficb_filter_ctrl u_filter (
        .bwCode(filter_bandwidth_select),
        .typeComplex(filter_type_select),
        .chipOn(chipOn),
        .bwValid(bandwidthValid),
        .filterOn(filterOn)
    );

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_resetImage;
        @(posedge clk) $fell(rst) |-> device_enable && !idleMode &&
            filter_centre_setting == 7'h58 && filter_type_select && filter_gain_select;
    endproperty
    a_resetImage: assert property (p_resetImage) else $error("bad reset image");

    property p_idleBlocks;
        @(posedge clk) disable iff (rst) idleMode |-> !highAmpEn && !lowAmpEn && !filterOn;
    endproperty
    a_idleBlocks: assert property (p_idleBlocks) else $error("idle not honoured");

    property p_disableBlocks;
        @(posedge clk) disable iff (rst) !device_enable |-> !highMixEn && !lowMixEn;
    endproperty
    a_disableBlocks: assert property (p_disableBlocks) else $error("chip off leaks");

    property p_ampDecode;
        @(posedge clk) disable iff (rst) chipOn |->
            highAmpEn == (amplifier_band_select == 2'h0) &&
            lowAmpEn == (amplifier_band_select == 2'h1);
    endproperty
    a_ampDecode: assert property (p_ampDecode) else $error("amp decode");

    property p_mixDecode;
        @(posedge clk) disable iff (rst) chipOn |->
            highMixEn == (mixer_band_select == 2'h0) && lowMixEn == (mixer_band_select == 2'h1);
    endproperty
    a_mixDecode: assert property (p_mixDecode) else $error("mixer decode");

    property p_bwLowpassOnly;
        @(posedge clk) disable iff (rst)
            filter_type_select && filter_bandwidth_select inside {3'h3, 3'h4, 3'h7} |->
            !bandwidthValid;
    endproperty
    a_bwLowpassOnly: assert property (p_bwLowpassOnly) else $error("bw legality");

    property p_writeLands;
        @(posedge clk) disable iff (rst)
            accept && write && wordIdx == RFICB_IDX_CONFIG && byteenable == 4'hF |=>
            configWord_reg == $past(writedata);
    endproperty
    a_writeLands: assert property (p_writeLands) else $error("config write lost");

    property p_readBack;
        @(posedge clk) disable iff (rst)
            accept && read && wordIdx == RFICB_IDX_CLKDIV |=> readdata == $past(clkDiv_reg);
    endproperty
    a_readBack: assert property (p_readBack) else $error("divider readback");

    property p_oneWait;
        @(posedge clk) disable iff (rst) accept |=> !waitrequest ##1 !ack_reg;
    endproperty
    a_oneWait: assert property (p_oneWait) else $error("wait length");

    property p_holdWhenOff;
        @(posedge clk) disable iff (rst) !device_enable && !(accept && write) |=>
            $stable(configWord_reg) && $stable(clkDiv_reg);
    endproperty
    a_holdWhenOff: assert property (p_holdWhenOff) else $error("content lost");

    c_writeConfig: cover property (@(posedge clk) accept && write && wordIdx == RFICB_IDX_CONFIG);
    c_readDiv: cover property (@(posedge clk) accept && read && wordIdx == RFICB_IDX_CLKDIV);
    c_chipOff: cover property (@(posedge clk) $fell(device_enable));
    c_badAddr: cover property (@(posedge clk) accept && !isMapped(wordIdx));
endmodule

// ===== tb/rficb_bank_tb.sv
// self-checking testbench for the rf/if configuration register bank
`timescale 1ns/100ps
module rficb_bank_tb;
    import rficb_pkg::*;
    logic clk, rst, read, write, waitrequest;
    logic [RFICB_ADDR_W-1:0] address;
    logic [31:0] writedata, readdata, testWord, cfgVal, divVal;
    logic [3:0] byteenable;
    logic [1:0] response, amplifier_band_select, mixer_band_select;
    logic device_enable, idleMode, mixer_pole_select, filter_order_select;
    logic filter_type_select, filter_gain_select, highAmpEn, lowAmpEn, highMixEn;
    logic lowMixEn, filterOn, bandwidthValid, pre_fractional_divider_select, clock_output_select;
    logic [6:0] filter_centre_setting;
    logic [2:0] filter_bandwidth_select;
    logic [11:0] sample_div_l_count, sample_div_m_count;
    logic [33:0] expQ[$];
    int n_fail = 0;
    int n_checks = 0;
    int seed = 32'hCAC79837;

    rficb_bank rficb_bank_inst (.clk, .rst, .address, .read, .write, .writedata, .byteenable,
        .readdata, .waitrequest, .response, .device_enable, .idleMode, .mixer_pole_select,
        .amplifier_band_select, .mixer_band_select, .filter_centre_setting,
        .filter_bandwidth_select, .filter_order_select, .filter_type_select,
        .filter_gain_select, .highAmpEn, .lowAmpEn, .highMixEn, .lowMixEn, .filterOn,
        .bandwidthValid, .sample_div_l_count, .sample_div_m_count,
        .pre_fractional_divider_select, .clock_output_select, .testWord);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic fail(input string msg);
        n_fail++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask

    // wide enough for response and read data together, so the response code is compared too
    task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string msg);
        n_checks++;
        if (got !== exp) fail(msg);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // avalon master: request held until waitrequest is seen low at an edge
    // ----------------------------------------------------------------
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
        input logic [3:0] be);
        int k = 0;
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        byteenable <= be;
        do begin
            @(posedge clk);
            k++;
        end while (waitrequest !== 1'b0 && k < 50);
        if (k >= 50) fail("bus answer missing");
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] r);
        expQ.push_back({r, e});
        bus(1'b0, a, 32'h00000000, 4'hF);
    endtask

    // read answers are matched against the oldest note at the edge after acceptance, where waitrequest is low
    always @(posedge clk) begin
        if (read === 1'b1 && waitrequest === 1'b0) begin
            if (expQ.size() == 0) fail("read answer without request");
            else chk({response, readdata}, expQ.pop_front(), "read data or response");
        end
    end

    // host keeps the fixed reserved patterns and the preserved reserved pair
    function automatic logic [31:0] cfg(input logic [1:0] ei, input logic p,
        input logic [1:0] am, input logic [1:0] mx, input logic [6:0] c,
        input logic [2:0] bw, input logic [2:0] otg);
        return {ei, 4'hF, 4'hA, 4'h9, p, am, mx, c, bw, otg};
    endfunction

    task automatic chkCfg(input logic [31:0] v);
        logic on;
        @(negedge clk);
        on = v[31] & ~v[30];
        chk(device_enable, v[31], "enable");
        chk(idleMode, v[30], "idle");
        chk(filterOn, on, "filter on");
        chk(mixer_pole_select, v[17], "pole");
        chk({highAmpEn, lowAmpEn}, {on && v[16:15] == 2'h0, on && v[16:15] == 2'h1}, "amp");
        chk({highMixEn, lowMixEn}, {on && v[14:13] == 2'h0, on && v[14:13] == 2'h1}, "mix");
        chk({amplifier_band_select, mixer_band_select}, v[16:13], "band fields");
        chk(filter_centre_setting, v[12:6], "centre");
        chk(filter_bandwidth_select, v[5:3], "bandwidth");
        chk(bandwidthValid, v[5:3] < 3 || (!v[1] && v[5:3] inside {3, 4, 7}), "bw legal");
        chk({filter_order_select, filter_type_select, filter_gain_select}, v[2:0], "ord");
    endtask

    initial begin
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = '0;
        writedata = '0;
        byteenable = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // reserved nibbles reset to 8 and 8, so the image differs from the write patterns
        rd(6'h00, 32'hA2241603, 2'b00);
        chkCfg(32'hA2241603);
        rd(6'h28, 32'h00000000, 2'b00);
        $display("test reset done");
        // every bandwidth code under both filter types, all band codes, enable and idle
        for (int i = 0; i < 16; i++) begin
            cfgVal = cfg((i < 12) ? 2'b10 : 2'(i - 12), 1'($random(seed)), 2'(i % 4),
                2'((i + 1) % 4), 7'($random(seed)), 3'(i), {1'($random(seed)), i[3], 1'($random(seed))});
            bus(1'b1, 6'h00, cfgVal, 4'hF);
            rd(6'h00, cfgVal, 2'b00);
            chkCfg(cfgVal);
        end
        $display("test field sweep done");
        // chip disabled: bank still writable and readable
        bus(1'b1, 6'h00, cfg(2'b00, 1'b0, 2'h2, 2'h2, 7'h58, 3'h0, 3'h3), 4'hF);
        for (int i = 0; i < 4; i++) begin
            divVal = $random(seed);
            bus(1'b1, 6'h28, divVal, 4'hF);
            rd(6'h28, divVal & 32'h0FFFFFFC, 2'b00);
            @(negedge clk);
            chk({sample_div_l_count, sample_div_m_count}, divVal[27:4], "counts");
            chk({pre_fractional_divider_select, clock_output_select}, divVal[3:2], "sel");
        end
        $display("test divider done");
        // byte lane write touches only the lowest byte
        cfgVal = cfg(2'b10, 1'b1, 2'h1, 2'h0, 7'h7F, 3'h7, 3'h7);
        bus(1'b1, 6'h00, cfgVal, 4'hF);
        bus(1'b1, 6'h00, 32'h00000000, 4'h1);
        rd(6'h00, cfgVal & 32'hFFFFFF00, 2'b00);
        chkCfg(cfgVal & 32'hFFFFFF00);
        $display("test byte lanes done");
        // reserved test word holds what is written; unmapped places read zero
        divVal = $random(seed);
        bus(1'b1, 6'h24, divVal, 4'hF);
        rd(6'h24, divVal, 2'b00);
        chk(testWord, divVal, "test word");
        bus(1'b1, 6'h04, 32'hFFFFFFFF, 4'hF);
        rd(6'h04, 32'h00000000, 2'b10);
        rd(6'h3C, 32'h00000000, 2'b10);
        $display("test unmapped done");
        chk(expQ.size(), 0, "reads left unanswered");
        close_out();
    end

    // whole run is about 170 bus cycles; this is far past it
    initial begin
        repeat (20000) @(posedge clk);
        fail("run timed out");
        close_out();
    end
endmodule
